// ===== hdl/pbist_core.sv
// Packet self-test generator, checker and APB register file
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module pbist_core
  import pbist_pkg::*;
#(
  parameter int SYNC_LOSS_N = 4,
  parameter int LOCK_N      = 4
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output pbist_byte_t      tx_o,
  input  pbist_byte_t      rx_i,
  output logic [4:0]       loop_ctrl_o,
  output logic             irq_o
);

  // Refuse run lengths the 4-bit run counters cannot reach
  if (SYNC_LOSS_N < 1 || SYNC_LOSS_N > 15 || LOCK_N < 1 || LOCK_N > 15) begin : g_bad_param
    $error("pbist_core: SYNC_LOSS_N and LOCK_N must be 1..15");
  end

  // Eight serial steps of x^15+x^14+1; new bits enter at bit 0
  function automatic logic [14:0] lfsr8(input logic [14:0] s);
    logic [14:0] v;
    v = s;
    for (int i = 0; i < 8; i++) begin
      v = {v[13:0], v[14] ^ v[13]};
    end
    return v;
  endfunction : lfsr8

  logic [15:0]       ctrl;
  logic [15:0]       pkt_len;
  logic [15:0]       gap_len;
  logic [15:0]       err_cnt;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic              en_d;
  pbist_gen_t        gen_st;
  logic [14:0]       gen_lfsr;
  logic [15:0]       gen_cnt;
  logic [14:0]       chk_lfsr;
  logic              chk_lock;
  logic              chk_lost;
  logic [3:0]        miss_run;
  logic [3:0]        hit_run;

  logic              acc;
  logic              wr;
  logic              rd;
  logic [5:0]        idx;
  logic              mapped;
  logic              enable;
  logic              start;
  logic              one_pkt;
  logic              single_cnt;
  logic [15:0]       next_len;
  logic [14:0]       gen_next;
  logic [14:0]       chk_pred;
  logic              chk_match;
  logic              chk_act;
  logic              cnt_hit;
  logic [IRQ_W-1:0]  irq_ev;

  // APB decode; the access completes in its second cycle
  assign acc    = psel_i & penable_i & ~pready_o;
  assign wr     = acc & pwrite_i;
  assign rd     = acc & ~pwrite_i;
  assign idx    = paddr_i[7:2];
  assign mapped = (paddr_i[1:0] == 2'b00) &&
                  (idx == IDX_CTRL || idx == IDX_ERRCNT || idx == IDX_PKTLEN ||
                   idx == IDX_GAPLEN || idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);

  assign enable     = ctrl[CTL_ENABLE];
  assign start      = enable & ~en_d;
  assign one_pkt    = ctrl[CTL_ONEPKT];
  assign single_cnt = ctrl[CTL_SINGLE];
  assign gen_next   = lfsr8(gen_lfsr);
  assign chk_pred   = lfsr8(chk_lfsr);
  assign chk_match  = (chk_pred[7:0] == rx_i.data);
  assign chk_act    = ce_i & enable & ~one_pkt & rx_i.valid;
  assign cnt_hit    = chk_act & chk_lock & ~chk_match & (err_cnt == CNT_MAX);

  // Packet length: register value, or a fixed size for one packet
  always_comb begin
    if (one_pkt) begin
      next_len = ctrl[CTL_BIGPKT] ? ONEPKT_LONG : ONEPKT_SHORT;
    end else if (pkt_len == 16'h0000) begin
      next_len = 16'h0001;
    end else begin
      next_len = pkt_len;
    end
  end

  // APB handshake, read data and error answer
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_o  <= acc;
      pslverr_o <= acc & ~mapped;
      if (rd && !mapped) begin
        prdata_o <= 32'h0000_0000;                          // Refused address reads as zero
      end else if (rd) begin
        case (idx)
          IDX_CTRL:     prdata_o <= {16'h0000, ctrl[15:12], chk_lock, chk_lost,
                                     gen_st != GEN_IDLE && gen_st != GEN_DONE,
                                     ctrl[8:0]};
          IDX_ERRCNT:   prdata_o <= {16'h0000, err_cnt};
          IDX_PKTLEN:   prdata_o <= {16'h0000, pkt_len};
          IDX_GAPLEN:   prdata_o <= {16'h0000, gap_len};
          IDX_IRQ_STAT: prdata_o <= {28'h000_0000, irq_stat};
          IDX_IRQ_MASK: prdata_o <= {28'h000_0000, irq_mask};
          default:      prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software writable registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl     <= CTRL_RST;
      pkt_len  <= PKTLEN_RST;
      gap_len  <= GAPLEN_RST;
      irq_mask <= MASK_RST;
      en_d     <= 1'b0;
    end else if (ce_i) begin
      en_d <= enable;
      if (wr && paddr_i[1:0] == 2'b00) begin
        case (idx)
          IDX_CTRL:     ctrl     <= pwdata_i[15:0] & CTL_WR_MASK;
          IDX_PKTLEN:   pkt_len  <= pwdata_i[15:0];
          IDX_GAPLEN:   gap_len  <= pwdata_i[15:0];
          IDX_IRQ_MASK: irq_mask <= pwdata_i[IRQ_W-1:0];
          default:      ;
        endcase
      end
    end
  end

  // Loopback selection drives the data path muxes; all zero is external
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      loop_ctrl_o <= 5'h00;
    end else if (ce_i) begin
      loop_ctrl_o <= ctrl[CTL_LOOP_LSB +: CTL_LOOP_W];
    end
  end

  // Generator sequencing: packet bytes then idle gap, or one packet then done
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gen_st   <= GEN_IDLE;
      gen_cnt  <= 16'h0000;
      gen_lfsr <= SEED;
      tx_o     <= '0;
    end else if (ce_i) begin
      if (!enable) begin
        gen_st   <= GEN_IDLE;
        gen_cnt  <= 16'h0000;
        tx_o     <= '0;
      end else begin
        case (gen_st)
          GEN_IDLE: begin
            gen_lfsr <= SEED;
            gen_cnt  <= next_len;
            gen_st   <= GEN_PKT;
            tx_o     <= '0;
          end
          GEN_PKT: begin
            tx_o.valid <= 1'b1;
            if (one_pkt) begin
              tx_o.data <= ONEPKT_BYTE;
            end else begin
              tx_o.data <= gen_next[7:0];
              gen_lfsr  <= gen_next;
            end
            if (gen_cnt == 16'h0001) begin
              gen_st  <= one_pkt ? GEN_DONE : GEN_GAP;
              gen_cnt <= (gap_len == 16'h0000) ? 16'h0001 : gap_len;
            end else begin
              gen_cnt <= gen_cnt - 16'h0001;
            end
          end
          GEN_GAP: begin
            tx_o <= '0;
            if (gen_cnt == 16'h0001) begin
              gen_st  <= GEN_PKT;
              gen_cnt <= next_len;
            end else begin
              gen_cnt <= gen_cnt - 16'h0001;
            end
          end
          GEN_DONE: begin
            tx_o <= '0;
          end
          default: begin
            gen_st <= GEN_IDLE;
            tx_o   <= '0;
          end
        endcase
      end
    end
  end

  // Checker: free-running prediction when locked, reseed when not
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chk_lfsr <= SEED;
      chk_lock <= 1'b0;
      chk_lost <= 1'b0;
      miss_run <= 4'h0;
      hit_run  <= 4'h0;
    end else if (ce_i) begin
      if (start) begin
        chk_lock <= 1'b0;
        chk_lost <= 1'b0;
        miss_run <= 4'h0;
        hit_run  <= 4'h0;
      end else if (chk_act) begin
        if (chk_lock) begin
          chk_lfsr <= chk_pred;
          if (chk_match) begin
            miss_run <= 4'h0;
          end else if (miss_run == 4'(SYNC_LOSS_N - 1)) begin
            chk_lock <= 1'b0;
            chk_lost <= 1'b1;
            hit_run  <= 4'h0;
            miss_run <= 4'h0;
          end else begin
            miss_run <= miss_run + 4'h1;
          end
        end else begin
          chk_lfsr <= {chk_lfsr[6:0], rx_i.data};
          if (!chk_match) begin
            hit_run <= 4'h0;
          end else if (hit_run == 4'(LOCK_N - 1)) begin
            chk_lock <= 1'b1;
            chk_lost <= 1'b0;
            hit_run  <= 4'h0;
          end else begin
            hit_run <= hit_run + 4'h1;
          end
        end
      end
    end
  end

  // Error byte counter, cleared when a test starts
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_cnt <= 16'h0000;
    end else if (ce_i) begin
      if (start) begin
        err_cnt <= 16'h0000;
      end else if (chk_act && chk_lock && !chk_match) begin
        if (err_cnt != CNT_MAX) begin
          err_cnt <= err_cnt + 16'h0001;
        end else if (!single_cnt) begin
          err_cnt <= 16'h0000;
        end else begin
          err_cnt <= err_cnt;
        end
      end
    end
  end

  // Events that raise interrupt status
  always_comb begin
    irq_ev               = '0;
    irq_ev[IRQ_LOCK]     = chk_act & ~chk_lock & chk_match & (hit_run == 4'(LOCK_N - 1));
    irq_ev[IRQ_SYNCLOST] = chk_act & chk_lock & ~chk_match & (miss_run == 4'(SYNC_LOSS_N - 1));
    irq_ev[IRQ_CNTMAX]   = cnt_hit;
    irq_ev[IRQ_PKTDONE]  = ce_i & enable & (gen_st == GEN_PKT) & one_pkt & (gen_cnt == 16'h0001);
  end

  // Sticky status bits; a read clears, a same-cycle event wins
  for (genvar b = 0; b < IRQ_W; b++) begin : g_irq
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        irq_stat[b] <= 1'b0;
      end else if (ce_i) begin
        if (irq_ev[b]) begin
          irq_stat[b] <= 1'b1;
        end else if (rd && paddr_i[1:0] == 2'b00 && idx == IDX_IRQ_STAT) begin
          irq_stat[b] <= 1'b0;
        end
      end
    end
  end

  // Interrupt line from registered status and mask
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

endmodule : pbist_core

// ===== include/pbist_pkg.sv
// Shared constants, register map and types of the packet self-test block
package pbist_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL     = 6'h16;
  localparam logic [5:0] IDX_ERRCNT   = 6'h1B;
  localparam logic [5:0] IDX_PKTLEN   = 6'h1C;
  localparam logic [5:0] IDX_GAPLEN   = 6'h1D;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h1E;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h1F;
  // Control/status register fields
  localparam int CTL_LOOP_LSB = 0;
  localparam int CTL_LOOP_W   = 5;
  localparam int CTL_BUSY     = 9;
  localparam int CTL_SYNCLOST = 10;
  localparam int CTL_LOCK     = 11;
  localparam int CTL_BIGPKT   = 12;
  localparam int CTL_ONEPKT   = 13;
  localparam int CTL_SINGLE   = 14;
  localparam int CTL_ENABLE   = 15;
  localparam logic [15:0] CTL_WR_MASK = 16'hF01F;
  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] PKTLEN_RST = 16'h0040;
  localparam logic [15:0] GAPLEN_RST = 16'h000C;
  localparam logic [3:0]  MASK_RST   = 4'h0;
  localparam logic [14:0] SEED       = 15'h7FFF;
  // Single packet lengths and payload
  localparam logic [15:0] ONEPKT_SHORT = 16'h0040;
  localparam logic [15:0] ONEPKT_LONG  = 16'h05EE;
  localparam logic [7:0]  ONEPKT_BYTE  = 8'h55;
  // Interrupt status bits
  localparam int IRQ_LOCK     = 0;
  localparam int IRQ_SYNCLOST = 1;
  localparam int IRQ_CNTMAX   = 2;
  localparam int IRQ_PKTDONE  = 3;
  localparam int IRQ_W        = 4;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // One byte of the data path with its valid qualifier
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pbist_byte_t;

  // Generator states, Gray coded along idle-packet-gap
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_PKT  = 2'b01,
    GEN_GAP  = 2'b11,
    GEN_DONE = 2'b10
  } pbist_gen_t;
endpackage : pbist_pkg

// ===== test/pbist_core_monitor.sv
// Port checker for the packet self-test block
`timescale 1ns/1ps
module pbist_core_monitor
  import pbist_pkg::*;
#(
  parameter int SYNC_LOSS_N = 4,
  parameter int LOCK_N      = 4
) (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input pbist_byte_t      tx_o,
  input pbist_byte_t      rx_i,
  input wire logic [4:0]  loop_ctrl_o,
  input wire logic        irq_o
);
  logic acc;
  logic wr_ctl;
  logic en_q;
  logic one_q;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Access taken, and a write of the control register
  assign acc    = psel_i && penable_i && !pready_o;
  assign wr_ctl = acc && pwrite_i && paddr_i == {IDX_CTRL, 2'b00};
  // Last written enable and one-packet bits
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q  <= 1'b0;
      one_q <= 1'b0;
    end else if (wr_ctl) begin
      en_q  <= pwdata_i[CTL_ENABLE];
      one_q <= pwdata_i[CTL_ONEPKT];
    end
  end
  AST_RDY_NEXT: assert property (acc |=> pready_o) else $error("no ready");
  AST_RDY_ONE: assert property (pready_o |=> !pready_o) else $error("long ready");
  AST_RDY_CAUSE: assert property (pready_o |-> $past(acc)) else $error("stray ready");
  AST_BAD_ADDR: assert property (acc && paddr_i[1:0] != 2'b00 |=>
    pslverr_o && (pwrite_i || prdata_o == 32'h0000_0000)) else $error("misaligned accepted");
  AST_LOOP: assert property (wr_ctl |=> ##1 loop_ctrl_o == $past(pwdata_i[4:0], 2))
    else $error("loopback select wrong");
  AST_TX_START: assert property (wr_ctl && pwdata_i[CTL_ENABLE] && !en_q |-> ##[2:5] tx_o.valid)
    else $error("no traffic");
  AST_TX_STOP: assert property (wr_ctl && !pwdata_i[CTL_ENABLE] |-> ##3 !tx_o.valid [*4])
    else $error("traffic after stop");
  AST_ONE_DATA: assert property (tx_o.valid && en_q && one_q |-> tx_o.data == ONEPKT_BYTE)
    else $error("single packet payload");
  COV_ONE: cover property (wr_ctl && pwdata_i[CTL_ONEPKT]);
  COV_ERR: cover property (pslverr_o);
  COV_IRQ: cover property ($rose(irq_o));
endmodule : pbist_core_monitor

bind pbist_core pbist_core_monitor #(.SYNC_LOSS_N(SYNC_LOSS_N), .LOCK_N(LOCK_N)) pbist_core_monitor_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_o(tx_o), .rx_i(rx_i), .loop_ctrl_o(loop_ctrl_o),
  .irq_o(irq_o));

// ===== test/pbist_core_tb.sv
// Self-checking bench for the packet self-test block
`timescale 1ns/1ps
module pbist_core_tb;
  import pbist_pkg::*;
  localparam logic [7:0] A_CT = {IDX_CTRL, 2'b00}, A_ER = {IDX_ERRCNT, 2'b00}, A_PL = {IDX_PKTLEN, 2'b00};
  localparam logic [7:0] A_GL = {IDX_GAPLEN, 2'b00}, A_ST = {IDX_IRQ_STAT, 2'b00}, A_MK = {IDX_IRQ_MASK, 2'b00};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        bgo = 1'b0;
  logic [3:0]  bn = 4'h0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_a23b;
  logic [31:0] prd;
  logic        rdy, serr, irq, lerr;
  logic [4:0]  lpc;
  pbist_byte_t tx, rx;
  logic [15:0] r, v;
  logic [7:0]  ra [5] = '{A_CT, A_ER, A_PL, A_GL, A_MK};
  logic [15:0] re [5] = '{CTRL_RST, 16'h0000, PKTLEN_RST, GAPLEN_RST, {12'h000, MASK_RST}};
  int          miscompares = 0;
  int          samples_checked = 0;
  int          pl, gl;
  always #12.5 clk = ~clk;
  pbist_core #(.SYNC_LOSS_N(4), .LOCK_N(4)) pbist_core_i (.core_clk_i(clk), .nrst_i(nrst), .ce_i(ce),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(serr), .tx_o(tx), .rx_i(rx), .loop_ctrl_o(lpc), .irq_o(irq));
  pbist_loop #(.LAT(2)) pbist_loop_i (.core_clk_i(clk), .nrst_i(nrst), .tx_i(tx), .bad_n_i(bn),
    .bad_go_i(bgo), .rx_o(rx));
  // Xorshift source and expected generator step
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [14:0] nxt(input logic [14:0] s);
    repeat (8) s = {s[13:0], s[14] ^ s[13]};
    return s;
  endfunction : nxt
  // Control readback: writable bits plus lock, sync lost, busy
  function automatic logic [15:0] cx(input logic [15:0] w, input logic [2:0] st);
    return (w & CTL_WR_MASK) | {4'h0, st, 9'h000};
  endfunction : cx
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      miscompares++;
    end
  endtask : chk
  // One APB transfer; waits for ready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = prd[15:0];
    lerr = serr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic spoil(input logic [3:0] n);
    bn  <= n;
    bgo <= 1'b1;
    @(posedge clk);
    bgo <= 1'b0;
    repeat (120) @(posedge clk);
  endtask : spoil
  // Follow np packets: lengths, gaps and payload bytes
  task automatic watch(input int np, input int pln, input int gln, input logic prbs);
    logic [14:0] s;
    int run, gap, w;
    s = SEED;
    w = 0;
    while (tx.valid !== 1'b1 && w < 100) begin
      @(posedge clk);
      w++;
    end
    repeat (np) begin
      run = 0;
      gap = 0;
      while (tx.valid === 1'b1) begin
        s = nxt(s);
        chk(tx.data, prbs ? s[7:0] : ONEPKT_BYTE);
        run++;
        @(posedge clk);
      end
      chk(run, pln);
      while (prbs && tx.valid !== 1'b1 && gap < 500) begin
        gap++;
        @(posedge clk);
      end
      if (prbs) chk(gap, gln);
    end
  endtask : watch
  task automatic stop_test();
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Main sequence: registers, traffic, checker, single packets
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 16'h0000, r);
      chk(r, re[i]);
    end
    apb(1'b0, 8'h00, 16'h0000, r);
    chk({lerr, r}, 17'h1_0000);
    apb(1'b1, 8'h5A, 16'hFFFF, r);
    chk(lerr, 1'b1);
    apb(1'b1, A_CT, 16'h0FFF, r);
    apb(1'b0, A_CT, 16'h0000, r);
    chk(r, 16'h001F);
    // Misaligned read of a live register answers zero with an error
    apb(1'b0, A_CT | 8'h01, 16'h0000, r);
    chk({lerr, r}, 17'h1_0000);
    repeat (3) begin
      v = {11'h000, 5'(rnd())};
      apb(1'b1, A_CT, v, r);
      repeat (2) @(posedge clk);
      chk(lpc, v[4:0]);
    end
    for (int k = 0; k < 2; k++) begin
      pl = k ? 3 + int'(rnd() % 8) : 0;
      gl = k ? 2 + int'(rnd() % 6) : 0;
      apb(1'b1, A_CT, 16'h0000, r);
      apb(1'b1, A_PL, 16'(pl), r);
      apb(1'b1, A_GL, 16'(gl), r);
      v = {1'b1, k[0], 9'h000, 5'(rnd())};
      apb(1'b1, A_CT, v, r);
      watch(4, pl ? pl : 1, gl ? gl : 1, 1'b1);
    end
    repeat (60) @(posedge clk);
    apb(1'b0, A_CT, 16'h0000, r);
    chk(r, cx(v, 3'b101));
    spoil(4'h2);
    apb(1'b0, A_ER, 16'h0000, r);
    chk(r, 16'h0002);
    apb(1'b1, A_MK, 16'h0002, r);
    spoil(4'h8);
    chk(irq, 1'b1);
    // Relock clears the sync-lost level again
    apb(1'b0, A_CT, 16'h0000, r);
    chk(r, cx(v, 3'b101));
    // Two earlier errors plus the run of misses that dropped lock
    apb(1'b0, A_ER, 16'h0000, r);
    chk(r, 16'h0006);
    apb(1'b0, A_ST, 16'h0000, r);
    chk(r, 16'h0003);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // Clock enable low must freeze a running packet byte
    while (tx.valid !== 1'b1) begin
      @(posedge clk);
    end
    ce <= 1'b0;
    @(posedge clk);
    r = {7'h00, tx};
    repeat (4) begin
      @(posedge clk);
      chk({7'h00, tx}, r);
    end
    ce <= 1'b1;
    apb(1'b1, A_MK, 16'h0008, r);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, A_CT, 16'h0000, r);
      apb(1'b0, A_ST, 16'h0000, r);
      v = {3'b101, k[0], 12'h000};
      apb(1'b1, A_CT, v, r);
      watch(1, k ? 1518 : 64, 0, 1'b0);
      repeat (4) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b0, A_CT, 16'h0000, r);
      chk(r, cx(v, 3'b000));
      apb(1'b0, A_ST, 16'h0000, r);
      chk(r, 16'h0008);
    end
    stop_test();
  end
  // Cuts a hang short far beyond the few thousand cycles the run needs
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule : pbist_core_tb

// ===== test/pbist_loop.sv
// Return path model: delays transmit bytes, spoils a requested count
`timescale 1ns/1ps
module pbist_loop
  import pbist_pkg::*;
#(
  parameter int LAT = 2
) (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  pbist_byte_t     tx_i,
  input  wire logic [3:0] bad_n_i,
  input  wire logic       bad_go_i,
  output pbist_byte_t     rx_o
);
  pbist_byte_t pipe [LAT];
  logic [3:0]  bad_cnt;
  // Delay line; idle slots carry changing junk so no stale byte looks valid
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bad_cnt <= 4'h0;
      for (int i = 0; i < LAT; i++) pipe[i] <= '0;
    end else begin
      if (bad_go_i) bad_cnt <= bad_n_i;
      else if (tx_i.valid && bad_cnt != 4'h0) bad_cnt <= bad_cnt - 4'h1;
      pipe[0].valid <= tx_i.valid;
      pipe[0].data  <= tx_i.valid ? tx_i.data ^ {8{bad_cnt != 4'h0}} : ~pipe[0].data;
      for (int i = 1; i < LAT; i++) pipe[i] <= pipe[i-1];
    end
  end
  assign rx_o = pipe[LAT-1];
endmodule : pbist_loop
